/* File: dv/dcf_front_properties.sv */
// port checker for the drawing command front end
module dcf_front_properties
  import dcf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // watched ports
  input dcf_host_t host,
  input wire logic rvalid,
  input dcf_cmd_t cmd_out,
  input dcf_stroke_t stroke_out,
  input wire logic stroke_ready,
  input wire logic stroke_busy,
  input wire logic [31:0] new_pixel,
  input wire logic [31:0] old_pixel,
  input wire logic [31:0] pixel_write
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_vec_wr;
    host.wr && host.addr == VEC_OFS && !stroke_busy;
  endsequence
  sequence s_pair_start;
    ##1 stroke_busy ##1 stroke_out.valid;
  endsequence
  property p_pair; s_vec_wr |-> s_pair_start; endproperty
  property p_rd; host.rd |=> rvalid; endproperty
  property p_deg;
    stroke_out.valid |-> stroke_out.angle_deg == 9'(stroke_out.angle) * 9'd45;
  endproperty
  property p_len; stroke_out.valid |-> stroke_out.pixels inside {[1:16]};
  endproperty
  property p_busy; stroke_out.valid |-> stroke_busy; endproperty
  // a stalled offer must not change under the rasteriser
  property p_held;
    stroke_out.valid && !stroke_ready
      |=> stroke_out.valid && $stable(stroke_out);
  endproperty
  property p_nop;
    cmd_out.valid && cmd_out.shape == SH_NONE |-> !cmd_out.write_px;
  endproperty
  property p_pat; cmd_out.valid && cmd_out.pattern
    |-> cmd_out.shape inside {SH_POLY, SH_TRAP4, SH_TRAPB};
  endproperty
  // every merged bit is either the new or the old pixel bit
  property p_mask;
    ((pixel_write ^ old_pixel) & ~(new_pixel ^ old_pixel)) == 32'h0;
  endproperty
  property p_issue;
    cmd_out.valid |-> $past(host.wr) && $past(host.addr) == CMD_OFS;
  endproperty
  a_pair: assert property (p_pair)
    else $error("stroke pair did not start");
  a_rd: assert property (p_rd)
    else $error("read not answered");
  a_deg: assert property (p_deg)
    else $error("stroke angle degrees wrong");
  a_len: assert property (p_len)
    else $error("stroke length out of range");
  a_busy: assert property (p_busy)
    else $error("stroke offered while idle");
  a_held: assert property (p_held)
    else $error("stalled stroke changed");
  a_nop: assert property (p_nop)
    else $error("no-op code writes pixels");
  a_pat: assert property (p_pat)
    else $error("pattern on wrong shape");
  a_mask: assert property (p_mask)
    else $error("pixel merge wrong");
  a_issue: assert property (p_issue)
    else $error("command issued without write");
endmodule // dcf_front_properties

bind dcf_front dcf_front_properties chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .host(host), .rvalid(rvalid),
  .cmd_out(cmd_out), .stroke_out(stroke_out), .stroke_ready(stroke_ready),
  .stroke_busy(stroke_busy), .new_pixel(new_pixel), .old_pixel(old_pixel),
  .pixel_write(pixel_write)
);

/* File: dv/dcf_raster_model.sv */
// rasteriser stand-in that takes strokes after a set stall
module dcf_raster_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // stroke handshake
  input wire logic offer,
  input wire logic [3:0] stall,
  output logic take
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // slow takes force the front end to hold its offer
  assign take = offer && wait_q >= stall;
  always @(posedge ref_clk) begin
    if (!rst_n || !offer || take) wait_q <= 4'h0;
    else wait_q <= wait_q + 4'h1;
  end
endmodule // dcf_raster_model

/* File: dv/test_draw_command_front_end.sv */
// self-checking bench for the drawing command front end
module test_draw_command_front_end import dcf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  dcf_host_t host = '0;
  logic [3:0] stall = 4'h2;
  logic [31:0] new_pixel = '0;
  logic [31:0] old_pixel = '0;
  logic [31:0] rdata, back_colour, fore_colour, pixel_write;
  logic rvalid, stroke_ready, stroke_busy;
  dcf_cmd_t cmd_out, got_cmd, ec, g;
  dcf_stroke_t stroke_out, es;
  dcf_stroke_t seen_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int i, c, s, k, n;
  logic [31:0] r, e, v, got_rd;
  logic [31:0] ex[3];
  logic [15:0] w;
  logic [7:0] b;
  logic [15:0] ofs[3] = '{BACK_OFS, FORE_OFS, MASK_OFS};
  logic [3:0] shp[16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                          4'h0, 4'h8, 4'h0, 4'h3, 4'h4, 4'h5, 4'h0, 4'h0};
  always #5 ref_clk = ~ref_clk;
  dcf_front dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .host(host), .rdata(rdata),
    .rvalid(rvalid), .cmd_out(cmd_out), .stroke_out(stroke_out),
    .stroke_ready(stroke_ready), .stroke_busy(stroke_busy),
    .back_colour(back_colour), .fore_colour(fore_colour),
    .new_pixel(new_pixel), .old_pixel(old_pixel), .pixel_write(pixel_write)
  );
  dcf_raster_model rast_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .offer(stroke_out.valid),
    .stall(stall), .take(stroke_ready)
  );
  always @(posedge ref_clk)
    if (stroke_out.valid && stroke_ready) seen_q.push_back(stroke_out);
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one host access; results captured just after the sampling edge
  task automatic acc(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    host <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge ref_clk);
    host <= '0;
    #1 got_cmd = cmd_out;
    got_rd = (rvalid === 1'b1) ? rdata : 32'hdead_beef;
    @(posedge ref_clk);
  endtask
  initial begin
    void'($urandom(32'hf651));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    acc(1'b1, PIXCTL_OFS, 32'h0000_e200);
    for (i = 0; i < 3; i++) begin
      ex[i] = $urandom();
      acc(1'b1, ofs[i], ex[i]);
      acc(1'b0, ofs[i], 32'h0);
      chk(got_rd, ex[i]);
    end
    chk(back_colour, ex[0]);
    chk(fore_colour, ex[1]);
    new_pixel <= $urandom();
    old_pixel <= $urandom();
    @(posedge ref_clk);
    #1 chk(pixel_write, (new_pixel & ex[2]) | (old_pixel & ~ex[2]));
    acc(1'b0, 16'h1234, 32'h0);
    chk(got_rd, 32'h0);
    $display("done: wide registers");
    @(posedge ref_clk);
    acc(1'b1, PIXCTL_OFS, 32'h0000_e000);
    r = $urandom();
    acc(1'b1, FORE_OFS, {16'h0, r[15:0]});
    acc(1'b1, FORE_OFS, {16'h0, r[31:16]});
    chk(fore_colour, r);
    acc(1'b0, FORE_OFS, 32'h0);
    chk({16'h0, got_rd[15:0]}, {16'h0, r[15:0]});
    acc(1'b0, FORE_OFS, 32'h0);
    chk({16'h0, got_rd[15:0]}, {16'h0, r[31:16]});
    $display("done: half registers");
    e = $urandom();
    acc(1'b1, EDGE2_OFS, {16'h0, e[15:0]});
    // no coordinates are written, so source alignment stays software's
    for (c = 0; c < 16; c++) begin
      r = $urandom();
      w = {c[2:0], 1'b0, c[3], r[10:0]};
      // the repeat makes a polygon or polyline a continuation
      repeat (2) acc(1'b1, CMD_OFS, {16'h0, w});
      ec = '0;
      ec.valid = 1'b1;
      ec.shape = dcf_shape_t'(shp[c]);
      ec.write_px = shp[c] != 4'h0;
      ec.pattern = c inside {11, 12, 13};
      ec.radial = w[3];
      ec.draw = w[4];
      ec.draw_direction = w[7:5];
      ec.second_draw_direction = (c inside {5, 13}) ? e[7:5] : 3'h0;
      ec.continued = shp[c] == 4'h3 || shp[c] == 4'h8;
      g = got_cmd;
      chk(32'(g), 32'(ec));
    end
    $display("done: command codes");
    for (s = 0; s < 2; s++) begin
      acc(1'b1, CMD_OFS, {16'h0, 3'b000, s[0], 12'h001});
      v = $urandom();
      stall <= v[19:16];
      seen_q.delete();
      acc(1'b1, VEC_OFS, {16'h0, v[15:0]});
      // a write while the pair is busy must be dropped
      acc(1'b1, VEC_OFS, {16'h0, ~v[15:0]});
      n = 0;
      while (stroke_busy !== 1'b0 && n < 100) begin
        @(posedge ref_clk);
        n++;
      end
      chk(seen_q.size(), 2);
      for (k = 0; k < 2 && k < seen_q.size(); k++) begin
        b = (s ^ k) ? v[7:0] : v[15:8];
        es.valid = 1'b1;
        es.draw_or_move_flag = b[4];
        es.angle = b[7:5];
        es.angle_deg = 9'(b[7:5]) * 9'd45;
        es.pixels = {1'b0, b[3:0]} + 5'h1;
        chk(32'(seen_q[k]), 32'(es));
      end
    end
    $display("done: short strokes");
    test_done();
  end
endmodule // test_draw_command_front_end

/* File: verilog/dcf_decode.sv */
// command code decode into drawing shape and fill style
module dcf_decode
  import dcf_pkg::*;
(
  // raw command and edge direction
  input wire logic [15:0] cmd,
  input wire logic [2:0] dir2,
  // decoded
  output dcf_cmd_t dec
);
  logic [3:0] code;
  assign code = {cmd[CMD_HI_BIT], cmd[CMD_LO_MSB:CMD_LO_LSB]};

  always_comb begin
    dec = '0;
    dec.radial = cmd[DIRTYP_BIT];
    dec.draw = cmd[DRAW_BIT];
    dec.draw_direction = cmd[DIR_MSB:DIR_LSB];
    dec.write_px = 1'b1;
    case (dcf_op_t'(code))
      OP_NOP: dec.write_px = 1'b0;
      OP_LINE: dec.shape = SH_LINE;
      OP_RECT: dec.shape = SH_RECT;
      OP_POLY: dec.shape = SH_POLY;
      OP_TRAP4: dec.shape = SH_TRAP4;
      OP_TRAPB: begin
        dec.shape = SH_TRAPB;
        dec.second_draw_direction = dir2;
      end
      OP_BLT: dec.shape = SH_BLT;
      OP_PAT: dec.shape = SH_PAT;
      OP_PLINE: dec.shape = SH_PLINE;
      OP_POLYP: begin
        dec.shape = SH_POLY;
        dec.pattern = 1'b1;
      end
      OP_TRAP4P: begin
        dec.shape = SH_TRAP4;
        dec.pattern = 1'b1;
      end
      OP_TRAPBP: begin
        dec.shape = SH_TRAPB;
        dec.pattern = 1'b1;
        dec.second_draw_direction = dir2;
      end
      default: dec.write_px = 1'b0;
    endcase
  end
endmodule // dcf_decode

/* File: verilog/dcf_front.sv */
// drawing command front end: registers, decode, short stroke sequencing
module dcf_front
  import dcf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // host register port
  input dcf_host_t host,
  output logic [31:0] rdata,
  output logic rvalid,
  // decoded command to the rasteriser
  output dcf_cmd_t cmd_out,
  // short strokes to the rasteriser
  output dcf_stroke_t stroke_out,
  input wire logic stroke_ready,
  output logic stroke_busy,
  // colour and plane mask to the pixel path
  output logic [31:0] back_colour,
  output logic [31:0] fore_colour,
  input wire logic [31:0] new_pixel,
  input wire logic [31:0] old_pixel,
  output logic [31:0] pixel_write
);
  logic [15:0] cmd_q;
  logic [15:0] cmd_src;
  logic swap_q;
  logic [15:0] edge2_q;
  logic [15:0] vec_q;
  logic [31:0] back_q;
  logic [31:0] fore_q;
  logic [31:0] mask_q;
  logic wide_q;
  logic half_q;
  logic [3:0] last_shape_q;
  dcf_cmd_t cmd_q2;
  dcf_cmd_t dec;
  dcf_stroke_t st_lo;
  dcf_stroke_t st_hi;
  dcf_stroke_t stroke_q;
  logic [31:0] rdata_q;
  logic rvalid_q;

  typedef enum logic [1:0] {
    SS_IDLE = 2'b00, SS_FIRST = 2'b01, SS_SECOND = 2'b10
  } dcf_ss_t;
  dcf_ss_t ss_q;

  logic wr_cmd, wr_edge2, wr_vec, wr_pix;
  logic acc_col;
  logic hit_back, hit_fore, hit_mask;
  assign wr_cmd = host.wr && host.addr == CMD_OFS;
  assign wr_edge2 = host.wr && host.addr == EDGE2_OFS;
  assign wr_vec = host.wr && host.addr == VEC_OFS;
  assign wr_pix = host.wr && host.addr == PIXCTL_OFS
    && host.wdata[15:12] == PIX_IDX_E;
  assign hit_back = host.addr == BACK_OFS;
  assign hit_fore = host.addr == FORE_OFS;
  assign hit_mask = host.addr == MASK_OFS;
  assign acc_col = (host.wr || host.rd) && (hit_back || hit_fore || hit_mask);
  // decode sees the write data on the write cycle, so the issued
  // command is the one just written, not the stale register
  assign cmd_src = wr_cmd ? host.wdata[15:0] : cmd_q;

  dcf_decode u_decode (
    .cmd(cmd_src),
    .dir2(edge2_q[DIR_MSB:DIR_LSB]),
    .dec(dec)
  );

  dcf_stroke u_lo (
    .vec(vec_q[7:0]),
    .st(st_lo)
  );

  dcf_stroke u_hi (
    .vec(vec_q[15:8]),
    .st(st_hi)
  );

  // command and edge registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_q <= REG_RST[15:0];
      edge2_q <= REG_RST[15:0];
    end else begin
      if (wr_cmd)
        cmd_q <= host.wdata[15:0];
      if (wr_edge2)
        edge2_q <= host.wdata[15:0];
    end
  end

  // decoded command is issued one cycle after a command write made while no stroke pair is busy
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_q2 <= '0;
      last_shape_q <= CNT_RST;
    end else begin
      cmd_q2 <= '0;
      if (wr_cmd && ss_q == SS_IDLE) begin
        cmd_q2 <= dec;
        cmd_q2.valid <= 1'b1;
        // a repeated polygon or polyline command reuses the prior points
        cmd_q2.continued <= dec.write_px && dec.shape == last_shape_q
          && (dec.shape == SH_POLY || dec.shape == SH_PLINE);
        last_shape_q <= dec.shape;
      end
    end
  end
  assign cmd_out = cmd_q2;

  // pixel control index e: width and half-select
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wide_q <= 1'b0;
      half_q <= 1'b0;
    end else if (wr_pix) begin
      wide_q <= host.wdata[WIDE_BIT];
      half_q <= host.wdata[HALF_BIT];
    end else if (acc_col && !wide_q) begin
      half_q <= ~half_q;
    end
  end

  // colour and mask registers, full or half word writes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      back_q <= REG_RST;
      fore_q <= REG_RST;
      mask_q <= REG_RST;
    end else if (host.wr) begin
      if (wide_q) begin
        if (hit_back)
          back_q <= host.wdata;
        if (hit_fore)
          fore_q <= host.wdata;
        if (hit_mask)
          mask_q <= host.wdata;
      end else if (half_q) begin
        if (hit_back)
          back_q[31:16] <= host.wdata[15:0];
        if (hit_fore)
          fore_q[31:16] <= host.wdata[15:0];
        if (hit_mask)
          mask_q[31:16] <= host.wdata[15:0];
      end else begin
        if (hit_back)
          back_q[15:0] <= host.wdata[15:0];
        if (hit_fore)
          fore_q[15:0] <= host.wdata[15:0];
        if (hit_mask)
          mask_q[15:0] <= host.wdata[15:0];
      end
    end
  end

  // read back of colour and mask
  logic [31:0] sel;
  always_comb begin
    sel = 32'h0000_0000;
    if (hit_back)
      sel = back_q;
    else if (hit_fore)
      sel = fore_q;
    else if (hit_mask)
      sel = mask_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= REG_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= host.rd;
      if (host.rd) begin
        if (wide_q)
          rdata_q <= sel;
        else if (half_q)
          rdata_q <= {16'h0000, sel[31:16]};
        else
          rdata_q <= {16'h0000, sel[15:0]};
      end
    end
  end
  assign rdata = rdata_q;
  assign rvalid = rvalid_q;

  // packed vector pair register; the swap bit is frozen with the pair so
  // a command written mid-pair cannot reorder strokes already on offer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vec_q <= REG_RST[15:0];
      swap_q <= 1'b0;
    end else if (wr_vec && ss_q == SS_IDLE) begin
      vec_q <= host.wdata[15:0];
      swap_q <= cmd_q[SWAP_BIT];
    end
  end

  // writes to the vector register while busy are dropped, so the host
  // must watch stroke_busy; cheaper than a second holding register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ss_q <= SS_IDLE;
      stroke_q <= '0;
    end else begin
      case (ss_q)
        SS_IDLE: begin
          stroke_q <= '0;
          if (wr_vec)
            ss_q <= SS_FIRST;
        end
        SS_FIRST: begin
          // swap 0 gives upper byte first
          stroke_q <= swap_q ? st_lo : st_hi;
          if (stroke_q.valid && stroke_ready) begin
            stroke_q <= swap_q ? st_hi : st_lo;
            ss_q <= SS_SECOND;
          end
        end
        SS_SECOND: begin
          if (stroke_ready) begin
            stroke_q <= '0;
            ss_q <= SS_IDLE;
          end
        end
        default: ss_q <= SS_IDLE;
      endcase
    end
  end
  assign stroke_out = stroke_q;
  assign stroke_busy = ss_q != SS_IDLE;

  // bitplane write mask
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_plane
      assign pixel_write[i] = mask_q[i] ? new_pixel[i] : old_pixel[i];
    end
  endgenerate

  assign back_colour = back_q;
  assign fore_colour = fore_q;
endmodule // dcf_front

/* File: verilog/dcf_pkg.sv */
// package for the drawing command front end
package dcf_pkg;
  // register offsets in the host i/o space
  localparam logic [15:0] CMD_OFS = 16'h9ae8;
  localparam logic [15:0] EDGE2_OFS = 16'h9aea;
  localparam logic [15:0] VEC_OFS = 16'h9ee8;
  localparam logic [15:0] BACK_OFS = 16'ha2e8;
  localparam logic [15:0] FORE_OFS = 16'ha6e8;
  localparam logic [15:0] MASK_OFS = 16'haae8;
  localparam logic [15:0] PIXCTL_OFS = 16'hbee8;
  // command register fields
  localparam int CMD_HI_BIT = 11;
  localparam int CMD_LO_MSB = 15;
  localparam int CMD_LO_LSB = 13;
  localparam int SWAP_BIT = 12;
  localparam int DIRTYP_BIT = 3;
  localparam int DRAW_BIT = 4;
  localparam int DIR_MSB = 7;
  localparam int DIR_LSB = 5;
  // packed vector fields, per byte
  localparam int LEN_MSB = 3;
  localparam int VDRAW_BIT = 4;
  // pixel control index e
  localparam logic [3:0] PIX_IDX_E = 4'he;
  localparam int WIDE_BIT = 9;
  localparam int HALF_BIT = 4;
  // reset values (power-on undefined, chosen zero)
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [3:0] CNT_RST = 4'h0;

  typedef enum logic [3:0] {
    OP_NOP = 4'b0000, OP_LINE = 4'b0001, OP_RECT = 4'b0010,
    OP_POLY = 4'b0011, OP_TRAP4 = 4'b0100, OP_TRAPB = 4'b0101,
    OP_BLT = 4'b0110, OP_PAT = 4'b0111, OP_U8 = 4'b1000,
    OP_PLINE = 4'b1001, OP_UA = 4'b1010, OP_POLYP = 4'b1011,
    OP_TRAP4P = 4'b1100, OP_TRAPBP = 4'b1101, OP_UE = 4'b1110,
    OP_UF = 4'b1111
  } dcf_op_t;

  typedef enum logic [3:0] {
    SH_NONE = 4'h0, SH_LINE = 4'h1, SH_RECT = 4'h2, SH_POLY = 4'h3,
    SH_TRAP4 = 4'h4, SH_TRAPB = 4'h5, SH_BLT = 4'h6, SH_PAT = 4'h7,
    SH_PLINE = 4'h8
  } dcf_shape_t;

  // decoded command handed to the rasteriser
  typedef struct packed {
    logic valid;
    dcf_shape_t shape;
    logic write_px;
    logic pattern;
    logic radial;
    logic draw;
    logic [2:0] draw_direction;
    logic [2:0] second_draw_direction;
    logic continued;
  } dcf_cmd_t;

  // one short stroke
  typedef struct packed {
    logic valid;
    logic draw_or_move_flag;
    logic [2:0] angle;
    logic [8:0] angle_deg;
    logic [4:0] pixels;
  } dcf_stroke_t;

  // host access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } dcf_host_t;
endpackage : dcf_pkg

/* File: verilog/dcf_stroke.sv */
// unpacks one byte of the packed vector pair
module dcf_stroke
  import dcf_pkg::*;
(
  // byte in
  input wire logic [7:0] vec,
  // stroke out
  output dcf_stroke_t st
);
  always_comb begin
    st.valid = 1'b1;
    st.draw_or_move_flag = vec[VDRAW_BIT];
    st.angle = vec[DIR_MSB:DIR_LSB];
    st.angle_deg = 9'(vec[DIR_MSB:DIR_LSB]) * 9'd45;
    st.pixels = 5'(vec[LEN_MSB:0]) + 5'd1;
  end
endmodule // dcf_stroke
